// file: tb/cpu_core_model.sv
// Purpose: core side: mask bit and instruction ends
// Assumes: mask set after reset
// Notes:   LAG sets instruction length
`timescale 1ns/10ps
module cpu_core_model #(
	parameter int LAG = 3
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       clear_mask_i,
	input  wire logic [2:0] push_sel_i,
	output logic            mask_o,
	output logic            done_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt    <= 4'h0;
			done_o <= 1'b0;
			mask_o <= 1'b1;
		end else begin
			cnt    <= (cnt == 4'(LAG)) ? 4'h0 : cnt + 4'h1;
			done_o <= (cnt == 4'(LAG));
			if (push_sel_i == irq_pkg::PUSH_COND) begin
				mask_o <= 1'b1;
			end else if (clear_mask_i) begin
				mask_o <= 1'b0;
			end
		end
	end
endmodule : cpu_core_model

// file: tb/irq_monitor.sv
// Purpose: port checks on the vector block
// Assumes: one clock, async active-low reset
// Notes:   bound onto the top module
`timescale 1ns/10ps
module irq_monitor (
	input wire logic        ref_clk_i,
	input wire logic        resetn_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        reset_request_i,
	input wire logic        software_trap_instruction_i,
	input wire logic        global_mask_i,
	input wire logic        instr_done_i,
	input wire logic        entry_o,
	input wire logic [2:0]  push_sel_o,
	input wire logic        set_mask_o,
	input wire logic [4:0]  vector_o,
	input wire logic [15:0] vector_addr_o
);
	// =====
	// entry sequence and read port
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence stack_tail;
		push_sel_o == irq_pkg::PUSH_PC_HI ##1 push_sel_o == irq_pkg::PUSH_IDX
		##1 push_sel_o == irq_pkg::PUSH_ACC ##1 push_sel_o == irq_pkg::PUSH_COND;
	endsequence
	chk_stack_order: assert property (push_sel_o == irq_pkg::PUSH_PC_LO |=> stack_tail)
		else $error("stacking order broken");
	chk_pc_low_first: assert property (push_sel_o == irq_pkg::PUSH_PC_LO
		|-> $past(push_sel_o) == irq_pkg::PUSH_NONE) else $error("stacking not led by pc low");
	chk_push_entry: assert property (push_sel_o != irq_pkg::PUSH_NONE |-> entry_o)
		else $error("push outside entry");
	chk_mask_after: assert property (push_sel_o == irq_pkg::PUSH_COND |=> set_mask_o)
		else $error("mask not set after stacking");
	chk_mask_pulse: assert property (set_mask_o |=> !set_mask_o)
		else $error("mask pulse too long");
	chk_vec_pair: assert property (vector_addr_o == 16'hFFFE - {10'h000, vector_o, 1'b0})
		else $error("vector address mismatch");
	chk_wait_done: assert property (push_sel_o == irq_pkg::PUSH_PC_LO
		|-> $past(instr_done_i)) else $error("entry before boundary");
	chk_entry_gate: assert property ($rose(entry_o) |-> !$past(global_mask_i)
		|| $past(software_trap_instruction_i) || $past(reset_request_i))
		else $error("entry while masked");
	chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside slot");
endmodule : irq_monitor
bind irq_pin_vector_priority irq_monitor mon_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .reset_request_i(reset_request_i),
	.software_trap_instruction_i(software_trap_instruction_i), .global_mask_i(global_mask_i),
	.instr_done_i(instr_done_i), .entry_o(entry_o), .push_sel_o(push_sel_o),
	.set_mask_o(set_mask_o), .vector_o(vector_o), .vector_addr_o(vector_addr_o));

// file: tb/tb_top.sv
// Purpose: self-checking bench for the vector block
// Assumes: 25 MHz clock, read data one cycle late
// Notes:   core modelled beside the design
`timescale 1ns/10ps
module tb_top;
	logic        ref_clk_i, resetn_i, pin_i, wr_i, rd_i, reset_request_i, clear_mask;
	logic        software_trap_instruction_i, global_mask_i, instr_done_i, irq_o;
	logic        entry_o, set_mask_o, cpu_request_o;
	logic [3:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, rd_val;
	logic [8:0]  src_flag_i;
	logic [2:0]  push_sel_o;
	logic [4:0]  vector_o;
	logic [15:0] vector_addr_o;
	int          failures = 0;
	int          cmp_count = 0;
	logic [4:0]  row_vec [9] = '{5'h17, 5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h12, 5'h13};
	irq_pin_vector_priority dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pin_i(pin_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.src_flag_i(src_flag_i), .reset_request_i(reset_request_i),
		.software_trap_instruction_i(software_trap_instruction_i),
		.global_mask_i(global_mask_i), .instr_done_i(instr_done_i), .entry_o(entry_o),
		.push_sel_o(push_sel_o), .set_mask_o(set_mask_o), .vector_o(vector_o),
		.vector_addr_o(vector_addr_o), .cpu_request_o(cpu_request_o), .irq_o(irq_o));
	cpu_core_model #(.LAG(3)) core_u (.clk_i(ref_clk_i), .resetn_i(resetn_i),
		.clear_mask_i(clear_mask), .push_sel_i(push_sel_o), .mask_o(global_mask_i),
		.done_o(instr_done_i));
	// =====
	// tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : wr
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(posedge ref_clk_i);
		check(rdata_o, exp);
	endtask : rd_chk
	task automatic pin_case(input logic [7:0] c, input logic p0, input logic p1,
		input logic [7:0] exp);
		pin_i <= p0;
		repeat (4) @(posedge ref_clk_i);
		wr(irq_pkg::ADDR_PIN_CTRL, c | 8'h04);
		pin_i <= p1;
		repeat (6) @(posedge ref_clk_i);
		rd_chk(irq_pkg::ADDR_PIN_CTRL, exp);
	endtask : pin_case
	task automatic enter(input logic [8:0] f, input logic t, input logic r, input logic [4:0] v);
		int n;
		n = 0;
		src_flag_i <= f;
		software_trap_instruction_i <= t;
		reset_request_i <= r;
		clear_mask <= 1'b1;
		@(posedge ref_clk_i);
		clear_mask <= 1'b0;
		while (push_sel_o !== irq_pkg::PUSH_COND && n < 60) begin
			@(posedge ref_clk_i);
			n++;
		end
		src_flag_i <= 9'h000;
		software_trap_instruction_i <= 1'b0;
		reset_request_i <= 1'b0;
		@(posedge ref_clk_i);
		check(16'(n < 60), 16'h1);
		check(set_mask_o, 1'b1);
		check(vector_o, v);
		check(vector_addr_o, 16'hFFFE - {10'h000, v, 1'b0});
	endtask : enter
	task automatic summarize;
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// =====
	// stimulus
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		summarize();
	end
	initial begin
		{resetn_i, pin_i, wr_i, rd_i, reset_request_i, clear_mask} = 6'h00;
		software_trap_instruction_i = 1'b0;
		{addr_i, wdata_i, src_flag_i} = 21'h000000;
		repeat (10) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		check(push_sel_o, irq_pkg::PUSH_NONE);
		check(vector_addr_o, irq_pkg::VEC_TOP_ADDR);
		check({entry_o, set_mask_o, cpu_request_o, irq_o}, 4'h0);
		rd_chk(irq_pkg::ADDR_PIN_CTRL, irq_pkg::PIN_CTRL_RESET);
		pin_case(8'h30, 1'b0, 1'b1, 8'h38);
		pin_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		rd_chk(irq_pkg::ADDR_PIN_CTRL, 8'h38);
		check(cpu_request_o, 1'b0);
		pin_case(8'h10, 1'b1, 1'b0, 8'h18);
		pin_case(8'h20, 1'b0, 1'b1, 8'h20);
		pin_case(8'h30, 1'b1, 1'b0, 8'h30);
		pin_case(8'h31, 1'b0, 1'b1, 8'h39);
		wr(irq_pkg::ADDR_PIN_CTRL, 8'h35);
		rd_chk(irq_pkg::ADDR_PIN_CTRL, 8'h39);
		wr(irq_pkg::ADDR_INT_MASK, 8'h01);
		repeat (2) @(posedge ref_clk_i);
		check(irq_o, 1'b1);
		wr(4'hF, 8'hFF);
		rd_chk(4'hF, 8'h00);
		rd_chk(irq_pkg::ADDR_INT_MASK, 8'h01);
		wr(irq_pkg::ADDR_INT_STATUS, 8'h07);
		repeat (2) @(posedge ref_clk_i);
		check(irq_o, 1'b0);
		pin_case(8'h00, 1'b0, 1'b0, 8'h00);
		wr(irq_pkg::ADDR_SRC_ENABLE, 8'hFF);
		foreach (row_vec[i]) begin
			src_flag_i <= 9'h001 << i;
			repeat (3) @(posedge ref_clk_i);
			check(cpu_request_o, 1'b1);
			rd_chk(irq_pkg::ADDR_VECTOR, {3'h0, row_vec[i]});
			rd_chk(irq_pkg::ADDR_VEC_HIGH, 8'hFE - {2'h0, row_vec[i], 1'b0});
			rd_chk(irq_pkg::ADDR_VEC_LOW, 8'hFF - {2'h0, row_vec[i], 1'b0});
		end
		src_flag_i <= 9'h1FF;
		repeat (3) @(posedge ref_clk_i);
		rd_chk(irq_pkg::ADDR_VECTOR, 8'h02);
		wr(irq_pkg::ADDR_SRC_ENABLE, 8'hFE);
		src_flag_i <= 9'h101;
		repeat (3) @(posedge ref_clk_i);
		check(cpu_request_o, 1'b0);
		rd_chk(irq_pkg::ADDR_SRC_FLAG, 8'h01);
		wr(irq_pkg::ADDR_SRC_ENABLE, 8'hFF);
		enter(9'h044, 1'b0, 1'b0, 5'h05);
		enter(9'h000, 1'b1, 1'b0, 5'h01);
		enter(9'h004, 1'b1, 1'b1, 5'h00);
		enter(9'h000, 1'b0, 1'b1, 5'h00);
		resetn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		check(push_sel_o, irq_pkg::PUSH_NONE);
		check({entry_o, set_mask_o, cpu_request_o, irq_o}, 4'h0);
		rd_chk(irq_pkg::ADDR_INT_MASK, 8'h00);
		rd_chk(irq_pkg::ADDR_PIN_CTRL, irq_pkg::PIN_CTRL_RESET);
		summarize();
	end
endmodule : tb_top

// file: verilog/irq_pin_vector_priority.sv
// Purpose: pin interrupt detection, source gating, priority vectoring, entry sequencing
// Assumes: pin asynchronous to ref_clk_i; peripheral flags synchronous
// Notes:   register port 4-bit address, 8-bit data
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
module irq_pin_vector_priority (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        pin_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic [8:0]  src_flag_i,
	input  wire logic        reset_request_i,
	input  wire logic        software_trap_instruction_i,
	input  wire logic        global_mask_i,
	input  wire logic        instr_done_i,
	output logic             entry_o,
	output logic      [2:0]  push_sel_o,
	output logic             set_mask_o,
	output logic      [4:0]  vector_o,
	output logic      [15:0] vector_addr_o,
	output logic             cpu_request_o,
	output logic             irq_o
);
	// =========================================================
	// pin synchroniser and edge detect
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// =========================================================
	// pin control register
	logic pin_level_mode_select;
	logic pin_interrupt_local_enable;
	logic pin_function_enable;
	logic pin_polarity_select;
	logic pin_interrupt_flag;
	logic pin_armed;

	wire ctrl_wr = wr_i && (addr_i == irq_pkg::ADDR_PIN_CTRL);
	wire ack_wr  = ctrl_wr && wdata_i[irq_pkg::BIT_ACK];
	wire pin_asserted = pin_polarity_select ? pin_sync : ~pin_sync;
	wire prev_asserted = pin_polarity_select ? pin_prev : ~pin_prev;
	wire pin_edge  = pin_function_enable && pin_armed && pin_asserted
	                 && !prev_asserted;
	wire pin_level = pin_function_enable && pin_level_mode_select
	                 && pin_asserted;
	wire pin_set   = pin_edge || pin_level;
	// set wins over acknowledge; in edge mode the flag only clears by ack
	wire next_pin_flag = pin_set ? 1'b1 : (ack_wr ? 1'b0 : pin_interrupt_flag);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_level_mode_select      <= 1'b0;
			pin_interrupt_local_enable <= 1'b0;
			pin_function_enable        <= 1'b0;
			pin_polarity_select        <= 1'b0;
			pin_interrupt_flag         <= 1'b0;
			pin_armed                  <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				pin_level_mode_select      <= wdata_i[irq_pkg::BIT_LEVEL_MODE];
				pin_interrupt_local_enable <= wdata_i[irq_pkg::BIT_LOCAL_EN];
				pin_function_enable        <= wdata_i[irq_pkg::BIT_FUNC_EN];
				pin_polarity_select        <= wdata_i[irq_pkg::BIT_POLARITY];
			end
			// edge valid only after one settled sample under current setup
			pin_armed          <= pin_function_enable && !ctrl_wr;
			pin_interrupt_flag <= next_pin_flag;
		end
	end

	// =========================================================
	// source enables
	logic [8:0] src_enable;
	wire en_lo_wr = wr_i && (addr_i == irq_pkg::ADDR_SRC_ENABLE);
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_enable <= 9'h000;
		end else if (en_lo_wr) begin
			src_enable <= {wdata_i[0], wdata_i};
		end
	end

	// =========================================================
	// request vector and encoder
	wire [8:0] src_fwd = src_flag_i & src_enable;
	wire       pin_fwd = pin_interrupt_flag && pin_interrupt_local_enable;
	logic [31:0] request;
	always_comb begin
		request = 32'h0000_0000;
		request[irq_pkg::VEC_RESET]  = reset_request_i;
		request[irq_pkg::VEC_SWTRAP] = software_trap_instruction_i;
		request[irq_pkg::VEC_LOWSUP] = src_fwd[irq_pkg::SRC_LOWSUP];
		request[irq_pkg::VEC_PIN]    = pin_fwd;
		request[irq_pkg::VEC_T1CH0]  = src_fwd[irq_pkg::SRC_T1CH0];
		request[irq_pkg::VEC_T1CH1]  = src_fwd[irq_pkg::SRC_T1CH1];
		request[irq_pkg::VEC_T1OVF]  = src_fwd[irq_pkg::SRC_T1OVF];
		request[irq_pkg::VEC_T2CH0]  = src_fwd[irq_pkg::SRC_T2CH0];
		request[irq_pkg::VEC_T2OVF]  = src_fwd[irq_pkg::SRC_T2OVF];
		request[irq_pkg::VEC_KEYPAD] = src_fwd[irq_pkg::SRC_KEYPAD];
		request[irq_pkg::VEC_CONV]   = src_fwd[irq_pkg::SRC_CONV];
		request[irq_pkg::VEC_WAKEUP] = src_fwd[irq_pkg::SRC_WAKEUP];
	end

	logic        enc_any;
	logic [4:0]  enc_vector;
	logic [15:0] enc_high;
	logic [15:0] enc_low;
	vector_encoder u_encoder (
		.request_i   (request),
		.any_o       (enc_any),
		.vector_o    (enc_vector),
		.addr_high_o (enc_high),
		.addr_low_o  ()
	);
	assign enc_low = enc_high + 16'h0001;

	wire maskable_pending = |request[31:2];
	wire service_due = request[irq_pkg::VEC_SWTRAP] || request[irq_pkg::VEC_RESET]
	                   || (maskable_pending && !global_mask_i);

	// =========================================================
	// entry sequencer
	irq_pkg::entry_state_t state;
	irq_pkg::entry_state_t next_state;
	always_comb begin
		case (state)
			irq_pkg::ST_IDLE:  next_state = service_due ? irq_pkg::ST_WAIT : irq_pkg::ST_IDLE;
			irq_pkg::ST_WAIT:  next_state = instr_done_i ? irq_pkg::ST_PC_LO : irq_pkg::ST_WAIT;
			irq_pkg::ST_PC_LO: next_state = irq_pkg::ST_PC_HI;
			irq_pkg::ST_PC_HI: next_state = irq_pkg::ST_IDX;
			irq_pkg::ST_IDX:   next_state = irq_pkg::ST_ACC;
			irq_pkg::ST_ACC:   next_state = irq_pkg::ST_COND;
			irq_pkg::ST_COND:  next_state = irq_pkg::ST_FETCH;
			irq_pkg::ST_FETCH: next_state = irq_pkg::ST_IDLE;
			default:           next_state = irq_pkg::ST_IDLE;
		endcase
	end

	wire [2:0] next_push = (next_state == irq_pkg::ST_PC_LO) ? irq_pkg::PUSH_PC_LO :
	                       (next_state == irq_pkg::ST_PC_HI) ? irq_pkg::PUSH_PC_HI :
	                       (next_state == irq_pkg::ST_IDX) ? irq_pkg::PUSH_IDX :
	                       (next_state == irq_pkg::ST_ACC) ? irq_pkg::PUSH_ACC :
	                       (next_state == irq_pkg::ST_COND) ? irq_pkg::PUSH_COND :
	                       irq_pkg::PUSH_NONE;
	wire fetch_now = (next_state == irq_pkg::ST_FETCH);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state         <= irq_pkg::ST_IDLE;
			entry_o       <= 1'b0;
			push_sel_o    <= irq_pkg::PUSH_NONE;
			set_mask_o    <= 1'b0;
			vector_o      <= irq_pkg::VEC_RESET;
			vector_addr_o <= irq_pkg::VEC_TOP_ADDR;
			cpu_request_o <= 1'b0;
		end else begin
			state         <= next_state;
			entry_o       <= (next_state != irq_pkg::ST_IDLE);
			push_sel_o    <= next_push;
			set_mask_o    <= fetch_now;
			if (fetch_now) begin
				vector_o      <= enc_vector;
				vector_addr_o <= enc_high;
			end
			cpu_request_o <= enc_any;
		end
	end

	// =========================================================
	// interrupt status and mask
	logic [2:0] int_status;
	logic [2:0] int_mask;
	wire [2:0] int_event = {fetch_now, enc_any && !cpu_request_o, pin_edge};
	wire st_wr = wr_i && (addr_i == irq_pkg::ADDR_INT_STATUS);
	wire mk_wr = wr_i && (addr_i == irq_pkg::ADDR_INT_MASK);
	wire [2:0] st_clr = st_wr ? wdata_i[2:0] : 3'h0;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_status <= 3'h0;
			int_mask   <= 3'h0;
			irq_o      <= 1'b0;
		end else begin
			int_status <= int_event | (int_status & ~st_clr);
			if (mk_wr) begin
				int_mask <= wdata_i[2:0];
			end
			irq_o <= |((int_event | (int_status & ~st_clr)) & int_mask);
		end
	end

	// =========================================================
	// read port
	wire [7:0] ctrl_view = {2'h0, pin_polarity_select, pin_function_enable,
	                        pin_interrupt_flag, 1'b0, pin_interrupt_local_enable,
	                        pin_level_mode_select};
	wire [7:0] rd_mux = (addr_i == irq_pkg::ADDR_PIN_CTRL)   ? ctrl_view :
	                    (addr_i == irq_pkg::ADDR_SRC_FLAG)   ? src_flag_i[7:0] :
	                    (addr_i == irq_pkg::ADDR_SRC_ENABLE) ? src_enable[7:0] :
	                    (addr_i == irq_pkg::ADDR_VECTOR)     ? {3'h0, enc_vector} :
	                    (addr_i == irq_pkg::ADDR_VEC_HIGH)   ? enc_high[7:0] :
	                    (addr_i == irq_pkg::ADDR_VEC_LOW)    ? enc_low[7:0] :
	                    (addr_i == irq_pkg::ADDR_INT_STATUS) ? {5'h00, int_status} :
	                    (addr_i == irq_pkg::ADDR_INT_MASK)   ? {5'h00, int_mask} :
	                    8'h00;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rd_mux : 8'h00;
		end
	end
endmodule : irq_pin_vector_priority

// file: verilog/irq_pkg.sv
// Purpose: constants for the pin interrupt and vector priority block
// Assumes: 8-bit register port, 32 vector slots
// Notes:   vector address pair is base minus two per vector number
package irq_pkg;
	// =========================================================
	// register map
	localparam logic [3:0] ADDR_PIN_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_SRC_FLAG   = 4'h1;
	localparam logic [3:0] ADDR_SRC_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_VECTOR     = 4'h3;
	localparam logic [3:0] ADDR_VEC_HIGH   = 4'h4;
	localparam logic [3:0] ADDR_VEC_LOW    = 4'h5;
	localparam logic [3:0] ADDR_INT_STATUS = 4'h6;
	localparam logic [3:0] ADDR_INT_MASK   = 4'h7;
	// =========================================================
	// pin control fields
	localparam int BIT_LEVEL_MODE = 0;
	localparam int BIT_LOCAL_EN   = 1;
	localparam int BIT_ACK        = 2;
	localparam int BIT_FLAG       = 3;
	localparam int BIT_FUNC_EN    = 4;
	localparam int BIT_POLARITY   = 5;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	// =========================================================
	// source slots in the 9-bit flag/enable view
	localparam int SRC_WAKEUP    = 0;
	localparam int SRC_LOWSUP    = 1;
	localparam int SRC_T1CH0     = 2;
	localparam int SRC_T1CH1     = 3;
	localparam int SRC_T1OVF     = 4;
	localparam int SRC_T2CH0     = 5;
	localparam int SRC_T2OVF     = 6;
	localparam int SRC_KEYPAD    = 7;
	localparam int SRC_CONV      = 8;
	localparam int NUM_SRC       = 9;
	// =========================================================
	// vector numbers
	localparam logic [4:0] VEC_RESET  = 5'h00;
	localparam logic [4:0] VEC_SWTRAP = 5'h01;
	localparam logic [4:0] VEC_LOWSUP = 5'h02;
	localparam logic [4:0] VEC_PIN    = 5'h03;
	localparam logic [4:0] VEC_T1CH0  = 5'h05;
	localparam logic [4:0] VEC_T1CH1  = 5'h06;
	localparam logic [4:0] VEC_T1OVF  = 5'h07;
	localparam logic [4:0] VEC_T2CH0  = 5'h08;
	localparam logic [4:0] VEC_T2OVF  = 5'h0A;
	localparam logic [4:0] VEC_KEYPAD = 5'h12;
	localparam logic [4:0] VEC_CONV   = 5'h13;
	localparam logic [4:0] VEC_WAKEUP = 5'h17;
	localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
	// =========================================================
	// interrupt status bits
	localparam int IST_PIN_EDGE = 0;
	localparam int IST_REQUEST  = 1;
	localparam int IST_TAKEN    = 2;
	localparam int NUM_IST      = 3;
	// =========================================================
	// entry sequencer states
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_WAIT  = 8'h02,
		ST_PC_LO = 8'h04,
		ST_PC_HI = 8'h08,
		ST_IDX   = 8'h10,
		ST_ACC   = 8'h20,
		ST_COND  = 8'h40,
		ST_FETCH = 8'h80
	} entry_state_t;
	localparam logic [2:0] PUSH_PC_LO = 3'h0;
	localparam logic [2:0] PUSH_PC_HI = 3'h1;
	localparam logic [2:0] PUSH_IDX = 3'h2;
	localparam logic [2:0] PUSH_ACC = 3'h3;
	localparam logic [2:0] PUSH_COND = 3'h4;
	localparam logic [2:0] PUSH_NONE = 3'h7;
endpackage : irq_pkg

// file: verilog/vector_encoder.sv
// Purpose: picks the highest priority pending vector and its address pair
// Assumes: request bit n stands for vector n
// Notes:   purely combinational
`timescale 1ns/10ps
module vector_encoder (
	input  wire logic [31:0] request_i,
	output logic             any_o,
	output logic [4:0]       vector_o,
	output logic [15:0]      addr_high_o,
	output logic [15:0]      addr_low_o
);
	// =========================================================
	// lowest number wins
	function automatic logic [4:0] lowest_set(input logic [31:0] r);
		logic [4:0] v;
		v = 5'h1F;
		for (int i = 31; i >= 0; i--) begin
			if (r[i]) begin
				v = 5'(i);
			end
		end
		return v;
	endfunction : lowest_set

	assign any_o       = |request_i;
	assign vector_o    = lowest_set(request_i);
	assign addr_high_o = irq_pkg::VEC_TOP_ADDR - {10'h000, vector_o, 1'b0};
	assign addr_low_o  = addr_high_o + 16'h0001;
endmodule : vector_encoder
